// ==== logic/lcdps_top.sv ====
// lcd command decoder with display ram and sleep/standby power save
`timescale 1ns/1ps
module lcdps_top
	import lcdps_pkg::*;
#(
	parameter int BLINK_HALF_CYCLES = lcdps_pkg::BLINK_HALF_CYC
) (
	input  wire logic       CLK_SYS,
	input  wire logic       SYS_RST,
	input  wire logic       HW_RESET_N,
	input  wire logic       WR_STB,
	input  wire logic       RD_STB,
	input  wire logic       CMD_DATA_SELECT,
	input  wire logic [7:0] DIN,
	output logic      [7:0] DOUT,
	output logic            DISPLAY_ON,
	output logic            ENTIRE_ON,
	output logic            REVERSE,
	output logic            ADC_REVERSE,
	output logic            BIAS_SEL,
	output logic            SCAN_DIR,
	output logic      [5:0] START_LINE,
	output logic      [3:0] PAGE,
	output logic      [7:0] COLUMN,
	output logic      [2:0] POWER_CTRL,
	output logic      [4:0] LCD_DRIVE_LEVEL,
	output logic            TEST_MODE,
	output logic            OSC_RUN,
	output logic      [2:0] SUPPLY_ENABLE,
	output logic            DRIVE_ACTIVE,
	output logic            OUT_AT_VDD,
	output logic            INDICATOR_ON,
	output logic            INDICATOR_DRIVE,
	output logic            SLEEP,
	output logic            STANDBY,
	output logic            DISPLAY_OFF_LINK
);
	import lcdps_pkg::*;

	logic       rst;
	logic       cmd_wr;
	logic       data_wr;
	logic       data_rd;
	logic       stat_rd;
	logic       is_reset_cmd;
	logic       ram_we;
	logic [11:0] ram_addr;
	logic [7:0] ram_rdata;
	logic       blink_tick;

	// mode registers and their next values
	logic       rmw;
	logic       next_rmw;
	logic [7:0] rmw_col;
	logic [7:0] next_rmw_col;
	logic       indicator;
	logic       next_indicator;
	logic       reset_flag;
	logic       next_reset_flag;
	logic       next_display_on;
	logic       next_entire_on;
	logic       next_reverse;
	logic       next_adc;
	logic       next_bias;
	logic       next_scan;
	logic [5:0] next_start;
	logic [3:0] next_page;
	logic [7:0] next_col;
	logic [2:0] next_power;
	logic [4:0] next_volt;
	logic       next_test;
	lcdps_pm_e  pm_state;
	lcdps_pm_e  next_pm;
	logic       ps_request;

	// read pipeline: ram read data arrive one cycle after the strobe
	logic       rd_pend;
	logic       rd_sel;
	logic       next_rd_pend;
	logic       next_rd_sel;
	logic [7:0] next_dout;
	logic       blink;
	logic       next_blink;

	// every check below runs on the system clock and rests during reset
	default clocking chk_cb @(posedge CLK_SYS);
	endclocking
	default disable iff (rst);

	// hardware reset pin acts like the system reset, ram excepted
	assign rst     = SYS_RST | ~HW_RESET_N;
	assign cmd_wr  = WR_STB & ~CMD_DATA_SELECT;
	assign data_wr = WR_STB &  CMD_DATA_SELECT;
	assign data_rd = RD_STB &  CMD_DATA_SELECT;
	assign stat_rd = RD_STB & ~CMD_DATA_SELECT;
	assign is_reset_cmd = cmd_wr & (DIN == OP_RESET);

	// ram is reached in every power state
	assign ram_we   = data_wr & ~rst;
	assign ram_addr = {PAGE, COLUMN};

	lcdps_ram u_ram (
		.clk   (CLK_SYS),
		.we    (ram_we),
		.addr  (ram_addr),
		.wdata (DIN),
		.rdata (ram_rdata)
	);

	lcdps_blink_div #(
		.HALF_CYC (BLINK_HALF_CYCLES)
	) u_blink (
		.clk  (CLK_SYS),
		.rst  (rst),
		.run  (OSC_RUN),
		.tick (blink_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// command decode; undefined codes fall through and change nothing
	always_comb begin
		next_display_on = DISPLAY_ON;
		next_entire_on  = ENTIRE_ON;
		next_reverse    = REVERSE;
		next_adc        = ADC_REVERSE;
		next_bias       = BIAS_SEL;
		next_scan       = SCAN_DIR;
		next_start      = START_LINE;
		next_page       = PAGE;
		next_col        = COLUMN;
		next_power      = POWER_CTRL;
		next_volt       = LCD_DRIVE_LEVEL;
		next_test       = TEST_MODE;
		next_rmw        = rmw;
		next_rmw_col    = rmw_col;
		next_indicator  = indicator;
		next_reset_flag = 1'b0;
		// column advances on write, and on read outside read-modify-write
		if (data_wr || (data_rd && !rmw)) begin
			next_col = COLUMN + 8'h01;
		end
		if (cmd_wr) begin
			if ((DIN & MASK_LSB) == OP_DISP_ONOFF) begin
				next_display_on = DIN[0];
			end
			if ((DIN & MASK_LSB) == OP_ENTIRE) begin
				next_entire_on = DIN[0];
			end
			if ((DIN & MASK_LSB) == OP_REVERSE) begin
				next_reverse = DIN[0];
			end
			if ((DIN & MASK_LSB) == OP_ADC) begin
				next_adc = DIN[0];
			end
			if ((DIN & MASK_LSB) == OP_BIAS) begin
				next_bias = DIN[0];
			end
			if ((DIN & MASK_LSB) == OP_INDICATOR) begin
				next_indicator = DIN[0];
			end
			if (DIN[7:6] == OP_START_TOP) begin
				next_start = DIN[5:0];
			end
			if (DIN[7:4] == OP_PAGE_TOP) begin
				next_page = DIN[3:0];
			end
			if (DIN[7:4] == OP_COLHI_TOP) begin
				next_col = {DIN[3:0], COLUMN[3:0]};
			end
			if (DIN[7:4] == OP_COLLO_TOP) begin
				next_col = {COLUMN[7:4], DIN[3:0]};
			end
			if (DIN[7:4] == OP_SCAN_TOP) begin
				next_scan = DIN[SCAN_BIT];
			end
			if (DIN[7:3] == OP_POWER_TOP) begin
				next_power = DIN[2:0];
			end
			if (DIN[7:5] == OP_VOLT_TOP) begin
				next_volt = DIN[4:0];
			end
			if (DIN == OP_RMW) begin
				next_rmw     = 1'b1;
				next_rmw_col = COLUMN;
			end
			if (DIN == OP_END) begin
				next_rmw = 1'b0;
				next_col = rmw_col;
			end
			// release byte shares the test nibble, so it is excluded inside the nibble match
			if (DIN[7:4] == OP_TEST_TOP) begin
				next_test = (DIN != OP_TEST_REL);
			end
			if (DIN == OP_RESET) begin
				next_start      = START_RST;
				next_col        = COL_RST;
				next_page       = PAGE_RST;
				next_scan       = 1'b0;
				next_rmw        = 1'b0;
				next_test       = 1'b0;
				next_reset_flag = 1'b1;
			end
		end
	end

	// mode registers; nothing here reacts to power state
	always_ff @(posedge CLK_SYS) begin
		if (rst) begin
			DISPLAY_ON      <= 1'b0;
			ENTIRE_ON       <= 1'b0;
			REVERSE         <= 1'b0;
			ADC_REVERSE     <= 1'b0;
			BIAS_SEL        <= 1'b0;
			SCAN_DIR        <= 1'b0;
			START_LINE      <= START_RST;
			PAGE            <= PAGE_RST;
			COLUMN          <= COL_RST;
			POWER_CTRL      <= POWER_RST;
			LCD_DRIVE_LEVEL <= VOLT_RST;
			TEST_MODE       <= 1'b0;
			rmw             <= 1'b0;
			rmw_col         <= COL_RST;
			indicator       <= 1'b0;
			reset_flag      <= 1'b1;
		end else begin
			DISPLAY_ON      <= next_display_on;
			ENTIRE_ON       <= next_entire_on;
			REVERSE         <= next_reverse;
			ADC_REVERSE     <= next_adc;
			BIAS_SEL        <= next_bias;
			SCAN_DIR        <= next_scan;
			START_LINE      <= next_start;
			PAGE            <= next_page;
			COLUMN          <= next_col;
			POWER_CTRL      <= next_power;
			LCD_DRIVE_LEVEL <= next_volt;
			TEST_MODE       <= next_test;
			rmw             <= next_rmw;
			rmw_col         <= next_rmw_col;
			indicator       <= next_indicator;
			reset_flag      <= next_reset_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power state follows the display-off plus entire-on combination
	assign ps_request = ~next_display_on & next_entire_on;

	always_comb begin
		next_pm = pm_state;
		unique case (pm_state)
			PM_ACTIVE: begin
				if (ps_request) begin
					next_pm = next_indicator ? PM_STANDBY : PM_SLEEP;
				end
			end
			PM_STANDBY: begin
				if (!ps_request) begin
					next_pm = PM_ACTIVE;
				end else if (is_reset_cmd) begin
					next_pm = PM_SLEEP;
				end
			end
			PM_SLEEP: begin
				if (!ps_request) begin
					next_pm = PM_ACTIVE;
				end
			end
			default: begin
				next_pm = PM_ACTIVE;
			end
		endcase
	end

	// outputs come from next values so they track the state with no lag
	always_comb begin
		next_blink = blink;
		if (blink_tick) begin
			next_blink = ~blink;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (rst) begin
			pm_state         <= PM_ACTIVE;
			OSC_RUN          <= 1'b1;
			SUPPLY_ENABLE    <= POWER_RST;
			DRIVE_ACTIVE     <= 1'b0;
			OUT_AT_VDD       <= 1'b1;
			INDICATOR_ON     <= 1'b0;
			INDICATOR_DRIVE  <= 1'b0;
			SLEEP            <= 1'b0;
			STANDBY          <= 1'b0;
			DISPLAY_OFF_LINK <= 1'b1;
			blink            <= 1'b0;
		end else begin
			pm_state      <= next_pm;
			OSC_RUN       <= (next_pm != PM_SLEEP);
			SUPPLY_ENABLE <= (next_pm == PM_ACTIVE) ? next_power
				: POWER_RST;
			DRIVE_ACTIVE  <= (next_pm == PM_ACTIVE) & next_display_on;
			OUT_AT_VDD    <= (next_pm != PM_ACTIVE) | ~next_display_on;
			INDICATOR_ON  <= next_indicator & (next_pm != PM_SLEEP);
			INDICATOR_DRIVE  <= next_indicator & (next_pm != PM_SLEEP)
				& next_blink;
			SLEEP            <= (next_pm == PM_SLEEP);
			STANDBY          <= (next_pm == PM_STANDBY);
			DISPLAY_OFF_LINK <= ~((next_pm == PM_ACTIVE) & next_display_on);
			blink            <= next_blink;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host read path: status or ram byte lands on dout two edges on
	always_comb begin
		next_rd_pend = RD_STB;
		next_rd_sel  = CMD_DATA_SELECT;
		next_dout    = DOUT;
		if (rd_pend) begin
			if (rd_sel) begin
				next_dout = ram_rdata;
			end else begin
				next_dout = 8'h00;
				next_dout[STAT_BUSY]  = 1'b0;
				next_dout[STAT_ADC]   = ADC_REVERSE;
				next_dout[STAT_OFF]   = ~DISPLAY_ON;
				next_dout[STAT_RESET] = reset_flag;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (rst) begin
			rd_pend <= 1'b0;
			rd_sel  <= 1'b0;
			DOUT    <= 8'h00;
		end else begin
			rd_pend <= next_rd_pend;
			rd_sel  <= next_rd_sel;
			DOUT    <= next_dout;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sleep_osc_off_a: assert property (
		(pm_state == PM_SLEEP) |-> (!OSC_RUN && SUPPLY_ENABLE == 3'h0))
		else $error("oscillator or supply running in sleep");
	save_out_vdd_a: assert property (
		(pm_state != PM_ACTIVE) |-> (OUT_AT_VDD && !DRIVE_ACTIVE))
		else $error("driving while in power save");
	entry_hold_a: assert property (
		(pm_state == PM_ACTIVE) ##1 (pm_state != PM_ACTIVE) |->
		($stable(LCD_DRIVE_LEVEL) && $stable(POWER_CTRL)
		&& $stable(START_LINE)))
		else $error("settings changed on power-save entry");
	standby_ind_a: assert property (
		(pm_state == PM_STANDBY) |-> (INDICATOR_ON && OSC_RUN
		&& SUPPLY_ENABLE == 3'h0))
		else $error("standby without indicator drive");
	reset_to_sleep_a: assert property (
		(pm_state == PM_STANDBY && is_reset_cmd) |=> (pm_state == PM_SLEEP))
		else $error("reset in standby did not give sleep");
	test_entry_a: assert property (
		(cmd_wr && DIN[7:4] == 4'hF && DIN[3:0] != 4'h0) |=> TEST_MODE)
		else $error("test entry missed");
	test_release_a: assert property (
		(cmd_wr && (DIN == OP_RESET || DIN == OP_TEST_REL)) |=> !TEST_MODE)
		else $error("test mode not released");
	status_low_a: assert property (
		(stat_rd) ##1 (!rst) |=> (DOUT[3:0] == 4'h0 && DOUT[5] == ~DISPLAY_ON))
		else $error("status byte malformed");
	col_halves_a: assert property (
		(cmd_wr && DIN[7:4] == 4'h1) |=> (COLUMN[7:4] == $past(DIN[3:0])
		&& COLUMN[3:0] == $past(COLUMN[3:0])))
		else $error("column high nibble load wrong");
	ps_entry_a: assert property (
		(pm_state == PM_ACTIVE && ps_request) |=>
		(STANDBY == $past(next_indicator) && SLEEP == !$past(next_indicator)))
		else $error("wrong power-save state chosen");
endmodule : lcdps_top

// ==== logic/lcdps_pkg.sv ====
// shared constants of the lcd command decoder and power-save block
package lcdps_pkg;

	// opcode patterns, compared against the whole or masked command byte
	localparam logic [7:0] OP_DISP_ONOFF = 8'hAE; // mask FE
	localparam logic [7:0] OP_ADC        = 8'hA0; // mask FE
	localparam logic [7:0] OP_BIAS       = 8'hA2; // mask FE
	localparam logic [7:0] OP_ENTIRE     = 8'hA4; // mask FE
	localparam logic [7:0] OP_REVERSE    = 8'hA6; // mask FE
	localparam logic [7:0] OP_INDICATOR  = 8'hAC; // mask FE
	localparam logic [7:0] OP_RMW        = 8'hE0;
	localparam logic [7:0] OP_RESET      = 8'hE2;
	localparam logic [7:0] OP_END        = 8'hEE;
	localparam logic [7:0] OP_TEST_REL   = 8'hF0;
	localparam logic [7:0] MASK_LSB      = 8'hFE;
	localparam logic [1:0] OP_START_TOP  = 2'h1;  // bits 7:6
	localparam logic [3:0] OP_PAGE_TOP   = 4'hB;  // bits 7:4
	localparam logic [3:0] OP_COLHI_TOP  = 4'h1;
	localparam logic [3:0] OP_COLLO_TOP  = 4'h0;
	localparam logic [3:0] OP_SCAN_TOP   = 4'hC;
	localparam logic [3:0] OP_TEST_TOP   = 4'hF;
	localparam logic [4:0] OP_POWER_TOP  = 5'h05; // bits 7:3
	localparam logic [2:0] OP_VOLT_TOP   = 3'h4;  // bits 7:5

	// field positions
	localparam int SCAN_BIT   = 3;
	localparam int STAT_BUSY  = 7;
	localparam int STAT_ADC   = 6;
	localparam int STAT_OFF   = 5;
	localparam int STAT_RESET = 4;

	// reset values
	localparam logic [5:0] START_RST = 6'h00;
	localparam logic [3:0] PAGE_RST  = 4'h0;
	localparam logic [7:0] COL_RST   = 8'h00;
	localparam logic [2:0] POWER_RST = 3'h0;
	localparam logic [4:0] VOLT_RST  = 5'h00;

	// indicator blink timing, derived from the system clock
	localparam int CLK_KHZ         = 200000;
	localparam int BLINK_PERIOD_MS = 1000;
	localparam int BLINK_HALF_CYC  = CLK_KHZ * BLINK_PERIOD_MS / 2;

	// power state, one-hot
	typedef enum logic [2:0] {
		PM_ACTIVE  = 3'b001,
		PM_SLEEP   = 3'b010,
		PM_STANDBY = 3'b100
	} lcdps_pm_e;

endpackage : lcdps_pkg

// ==== logic/lcdps_ram.sv ====
// display ram, 16 pages by 256 columns, registered read port
`timescale 1ns/1ps
module lcdps_ram (
	input  wire logic       clk,
	input  wire logic       we,
	input  wire logic [11:0] addr,
	input  wire logic [7:0]  wdata,
	output logic      [7:0]  rdata
);
	logic [7:0] mem [0:4095];

	// no reset on purpose: contents survive every kind of reset
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule : lcdps_ram

// ==== logic/lcdps_blink_div.sv ====
// divider giving a one-cycle pulse each half blink period
`timescale 1ns/1ps
module lcdps_blink_div #(
	parameter int HALF_CYC = 4
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic run,
	output logic      tick
);
	logic [31:0] count;
	logic [31:0] next_count;
	logic        next_tick;

	// counter stops with the oscillator so sleep draws nothing here
	always_comb begin
		next_count = count;
		next_tick  = 1'b0;
		if (run) begin
			if (count == 32'(HALF_CYC - 1)) begin
				next_count = 32'h0;
				next_tick  = 1'b1;
			end else begin
				next_count = count + 32'h1;
			end
		end
	end

	// registers
	always_ff @(posedge clk) begin
		if (rst) begin
			count <= 32'h0;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end
endmodule : lcdps_blink_div

// ==== dv/lcdps_host.sv ====
// host processor model driving the parallel command and data port
`timescale 1ns/1ps
module lcdps_host (
	input  wire logic       clk,
	output logic            wr_stb,
	output logic            rd_stb,
	output logic            sel,
	output logic      [7:0] din,
	output logic            ext_supply_on,
	input  wire logic [7:0] dout
);
	// idle port, external supply assumed running at power-up
	initial begin
		wr_stb        = 1'b0;
		rd_stb        = 1'b0;
		sel           = 1'b0;
		din           = 8'h00;
		ext_supply_on = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// one strobed write; din shows the inverse once released so a stale
	// byte can never pass for a fresh one
	task automatic wr(input logic s, input logic [7:0] b);
		@(posedge clk);
		wr_stb <= 1'b1;
		sel    <= s;
		din    <= b;
		@(posedge clk);
		wr_stb <= 1'b0;
		din    <= ~b;
		@(posedge clk);
		#1;
	endtask : wr

	// one strobed read; the answer lands one edge after the taking edge
	task automatic rd(input logic s, output logic [7:0] q);
		@(posedge clk);
		rd_stb <= 1'b1;
		sel    <= s;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		#1;
		q = dout;
	endtask : rd

	// supply is cut before the power-save pair is sent, never after
	task automatic psave;
		@(posedge clk);
		ext_supply_on <= 1'b0;
		wr(1'b0, 8'hAE);
		wr(1'b0, 8'hA5);
	endtask : psave

	// periodic refresh: test release first, then display mode again
	task automatic refresh;
		wr(1'b0, 8'hF0);
		wr(1'b0, 8'hAF);
	endtask : refresh
endmodule : lcdps_host

// ==== dv/tb_lcdps_top.sv ====
// self-checking bench of the lcd command decoder and power save
`timescale 1ns/1ps
module tb_lcdps_top;
	import lcdps_pkg::*;
	logic       clk_sys, sys_rst, hw_reset_n, wr_stb, rd_stb, sel, ext_on;
	logic [7:0] din, dout, column, q;
	logic [5:0] start_line;
	logic [3:0] page;
	logic [2:0] power_ctrl, supply_en;
	logic [4:0] level;
	logic       disp_on, entire_on, reverse, adc_rev, bias_sel, scan_dir;
	logic       test_mode, osc_run, drive_act, out_vdd, ind_on, ind_drv;
	logic       sleep, standby, off_link, prev;
	int         error_cnt, samples_checked, n;

	typedef struct packed {
		logic [7:0] cmd;
		logic [3:0] sel;
		logic [7:0] exp;
	} lcdps_row_s;

	// command, output picked, value expected after it
	lcdps_row_s rows [0:23] = '{
		'{8'hAF, 4'h0, 8'h01},
		'{8'hA5, 4'h1, 8'h01},
		'{8'hA4, 4'h1, 8'h00},
		'{8'hA7, 4'h2, 8'h01},
		'{8'hA6, 4'h2, 8'h00},
		'{8'hC7, 4'h3, 8'h00},
		'{8'hCF, 4'h3, 8'h01},
		'{8'h7F, 4'h4, 8'h3F},
		'{8'h6A, 4'h4, 8'h2A},
		'{8'hBA, 4'h5, 8'h0A},
		'{8'h1C, 4'h6, 8'hC2},
		'{8'h05, 4'h6, 8'hC5},
		'{8'h2D, 4'h7, 8'h05},
		'{8'h2A, 4'h7, 8'h02},
		'{8'h9F, 4'h8, 8'h1F},
		'{8'h8A, 4'h8, 8'h0A},
		'{8'hAD, 4'h9, 8'h01},
		'{8'hAC, 4'h9, 8'h00},
		'{8'hA1, 4'hB, 8'h01},
		'{8'hF5, 4'hA, 8'h01},
		'{8'hF0, 4'hA, 8'h00},
		'{8'hFA, 4'hA, 8'h01},
		'{8'hE2, 4'hA, 8'h00},
		'{8'hAE, 4'h0, 8'h00}
	};

	lcdps_top #(.BLINK_HALF_CYCLES(8)) u_lcdps_top (
		.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .HW_RESET_N(hw_reset_n),
		.WR_STB(wr_stb), .RD_STB(rd_stb), .CMD_DATA_SELECT(sel),
		.DIN(din), .DOUT(dout), .DISPLAY_ON(disp_on),
		.ENTIRE_ON(entire_on), .REVERSE(reverse), .ADC_REVERSE(adc_rev),
		.BIAS_SEL(bias_sel), .SCAN_DIR(scan_dir), .START_LINE(start_line),
		.PAGE(page), .COLUMN(column), .POWER_CTRL(power_ctrl),
		.LCD_DRIVE_LEVEL(level), .TEST_MODE(test_mode), .OSC_RUN(osc_run),
		.SUPPLY_ENABLE(supply_en), .DRIVE_ACTIVE(drive_act),
		.OUT_AT_VDD(out_vdd), .INDICATOR_ON(ind_on),
		.INDICATOR_DRIVE(ind_drv), .SLEEP(sleep), .STANDBY(standby),
		.DISPLAY_OFF_LINK(off_link)
	);

	lcdps_host u_lcdps_host (
		.clk(clk_sys), .wr_stb(wr_stb), .rd_stb(rd_stb), .sel(sel),
		.din(din), .ext_supply_on(ext_on), .dout(dout)
	);

	////////////////////////////////////////////////////////////////////////
	// selects one decoded output, widened to a byte
	function automatic logic [7:0] pick(input logic [3:0] k);
		case (k)
		4'h0: pick = {7'h00, disp_on};
		4'h1: pick = {7'h00, entire_on};
		4'h2: pick = {7'h00, reverse};
		4'h3: pick = {7'h00, scan_dir};
		4'h4: pick = {2'h0, start_line};
		4'h5: pick = {4'h0, page};
		4'h6: pick = column;
		4'h7: pick = {5'h00, power_ctrl};
		4'h8: pick = {3'h0, level};
		4'h9: pick = {7'h00, ind_on};
		4'hA: pick = {7'h00, test_mode};
		default: pick = {7'h00, adc_rev};
		endcase
	endfunction : pick

	task automatic chk8(input string what, input logic [7:0] e,
		input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask : chk8

	task automatic chk1(input string what, input logic e, input logic g);
		chk8(what, {7'h00, e}, {7'h00, g});
	endtask : chk1

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////
	// 200 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// a hang far beyond the few hundred cycles of the tests ends the run
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		report_and_stop;
	end

	// main sequence
	initial begin
		sys_rst    = 1'b1;
		hw_reset_n = 1'b1;
		error_cnt  = 0;
		samples_checked = 0;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk1("display on", 1'b0, disp_on);
		chk1("osc run", 1'b1, osc_run);
		chk1("out at vdd", 1'b1, out_vdd);
		chk1("off link", 1'b1, off_link);
		$display("test reset done");
		// ram write and read at page 3, column 10h
		u_lcdps_host.wr(1'b0, 8'hB3);
		u_lcdps_host.wr(1'b0, 8'h11);
		u_lcdps_host.wr(1'b0, 8'h00);
		u_lcdps_host.wr(1'b1, 8'hAA);
		u_lcdps_host.wr(1'b1, 8'h55);
		chk8("column", 8'h12, column);
		u_lcdps_host.wr(1'b0, 8'h00);
		u_lcdps_host.wr(1'b0, 8'h11);
		u_lcdps_host.rd(1'b1, q);
		chk8("ram", 8'hAA, q);
		u_lcdps_host.rd(1'b1, q);
		chk8("ram", 8'h55, q);
		$display("test ram done");
		// command table, ends with a software reset and display off
		for (int i = 0; i < 24; i++) begin
			u_lcdps_host.wr(1'b0, rows[i].cmd);
			chk8("row", rows[i].exp, pick(rows[i].sel));
		end
		$display("test table done");
		chk8("start", 8'h00, pick(4'h4));
		chk8("page", 8'h00, pick(4'h5));
		chk8("column", 8'h00, column);
		chk1("scan", 1'b0, scan_dir);
		chk8("level", 8'h0A, pick(4'h8));
		u_lcdps_host.wr(1'b0, 8'hA3);
		chk1("bias", 1'b1, bias_sel);
		u_lcdps_host.rd(1'b0, q);
		chk8("status", 8'h60, q);
		$display("test status done");
		// sleep: indicator off, display off then entire on
		u_lcdps_host.psave();
		chk1("sleep", 1'b1, sleep);
		chk1("osc run", 1'b0, osc_run);
		chk8("supply", 8'h00, {5'h00, supply_en});
		chk1("out at vdd", 1'b1, out_vdd);
		chk1("drive", 1'b0, drive_act);
		chk1("off link", 1'b1, off_link);
		chk8("power held", 8'h02, pick(4'h7));
		u_lcdps_host.wr(1'b0, 8'hB3);
		u_lcdps_host.wr(1'b0, 8'h11);
		u_lcdps_host.rd(1'b1, q);
		chk8("ram kept", 8'hAA, q);
		u_lcdps_host.wr(1'b1, 8'h3C);
		u_lcdps_host.wr(1'b0, 8'h01);
		u_lcdps_host.rd(1'b1, q);
		chk8("ram in sleep", 8'h3C, q);
		u_lcdps_host.wr(1'b0, 8'hA4);
		chk1("sleep", 1'b0, sleep);
		chk1("osc run", 1'b1, osc_run);
		u_lcdps_host.wr(1'b0, 8'hAF);
		chk1("drive", 1'b1, drive_act);
		chk1("off link", 1'b0, off_link);
		chk8("supply", 8'h02, {5'h00, supply_en});
		chk1("out at vdd", 1'b0, out_vdd);
		$display("test sleep done");
		// standby: indicator on, then software reset moves to sleep
		u_lcdps_host.wr(1'b0, 8'hAD);
		u_lcdps_host.psave();
		chk1("standby", 1'b1, standby);
		chk1("osc run", 1'b1, osc_run);
		chk8("supply", 8'h00, {5'h00, supply_en});
		chk1("out at vdd", 1'b1, out_vdd);
		n = 0;
		prev = ind_drv;
		repeat (20) begin
			@(posedge clk_sys);
			#1;
			if (ind_drv !== prev)
				n++;
			prev = ind_drv;
		end
		chk1("blinking", 1'b1, n > 0);
		u_lcdps_host.wr(1'b0, 8'hE2);
		chk1("sleep", 1'b1, sleep);
		chk1("standby", 1'b0, standby);
		u_lcdps_host.wr(1'b0, 8'hA4);
		chk1("sleep", 1'b0, sleep);
		$display("test standby done");
		// test mode left through the hardware reset pin
		u_lcdps_host.wr(1'b0, 8'hF7);
		chk1("test", 1'b1, test_mode);
		@(posedge clk_sys);
		hw_reset_n <= 1'b0;
		@(posedge clk_sys);
		hw_reset_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk1("test", 1'b0, test_mode);
		u_lcdps_host.refresh();
		chk1("display on", 1'b1, disp_on);
		$display("test reset pin done");
		report_and_stop;
	end
endmodule : tb_lcdps_top
